// >>> logic/amp_fault_manager.sv
// fault classification, fault pin, recovery and interrupt logic of the amplifier
// assumes synchronous condition inputs and a one-cycle register port
//
// Design decisions made here: strobed register access and the address decode.
`timescale 1ns/100ps
`default_nettype none

module amp_fault_manager
  import amp_fault_pkg::*;
#(
  parameter int unsigned DC_CYCLES       = DC_DETECT_CYC,
  parameter int unsigned RECOVERY_CYCLES = RECOVERY_CYC
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  // protection conditions
  input  wire logic              ov_cond_i,
  input  wire logic              uv_cond_i,
  input  wire logic              clk_ratio_bad_i,
  input  wire logic              clk_rate_bad_i,
  input  wire logic              clk_stopped_i,
  input  wire logic              oc_cond_i,
  input  wire logic              ot_cond_i,
  input  wire logic              ot_below_hyst_i,
  input  wire logic [NUM_CH-1:0] out_p_i,
  input  wire logic [NUM_CH-1:0] out_n_i,
  // shutdown pin and open-drain fault pin
  input  wire logic              amp_shutdown_n_i,
  input  wire logic              fault_out_n_i,
  output logic                   fault_out_n_o,
  output logic                   fault_out_n_oe_n_o,
  output logic                   power_stage_en_o,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              we_i,
  input  wire logic              re_i,
  output logic      [DATA_W-1:0] rdata_o,
  output logic                   irq_o
);

  // ==========================================================================
  // dc detection per channel
  logic [NUM_CH-1:0] dc_ch;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_dc
      dc_duty_monitor #(
        .HOLD_CYCLES (DC_CYCLES)
      ) u_mon (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .out_p_i    (out_p_i[ch]),
        .out_n_i    (out_n_i[ch]),
        .dc_err_o   (dc_ch[ch])
      );
    end
  endgenerate

  // ==========================================================================
  // state
  typedef struct packed {
    logic               sd_bit;
    logic [2:0]         lat;
    logic               toggled;
    logic [CNT_W-1:0]   timer;
    logic [NUM_ERR-1:0] prev;
    logic [NUM_ERR-1:0] irq_stat;
    logic [NUM_ERR-1:0] irq_mask;
    logic [DATA_W-1:0]  rdata;
    logic               fault_drv;
    logic               fault_oe_n;
    logic               pwr_en;
    logic               irq;
  } mgr_state_t;

  mgr_state_t s_reg;
  mgr_state_t s_next;

  // ==========================================================================
  // next state
  always_comb begin
    logic               sd_n;
    logic               clk_err;
    logic [2:0]         cond;
    logic [2:0]         lat_set;
    logic [2:0]         lat_clr;
    logic               clear_ok;
    logic [NUM_ERR-1:0] err;
    err      = '0;
    sd_n     = amp_shutdown_n_i & s_reg.sd_bit;
    clk_err  = clk_ratio_bad_i | clk_rate_bad_i | clk_stopped_i;
    cond     = {ot_cond_i, |dc_ch, oc_cond_i};
    lat_set  = cond & {3{sd_n}};
    clear_ok = s_reg.toggled && (s_reg.timer == '0);
    lat_clr  = {clear_ok & ot_below_hyst_i, clear_ok, clear_ok};
    s_next   = s_reg;
    s_next.rdata = '0;

    // latching errors and recovery
    s_next.lat = (s_reg.lat & ~lat_clr) | lat_set;
    if (!sd_n && (|s_reg.lat)) begin
      s_next.toggled = 1'b1;
    end
    if (s_next.lat == 3'b000) begin
      s_next.toggled = 1'b0;
    end
    if (|(lat_set & ~s_reg.lat)) begin
      s_next.timer = CNT_W'(RECOVERY_CYCLES);
    end else if (s_reg.timer != '0) begin
      s_next.timer = s_reg.timer - CNT_W'(1);
    end

    // live error vector
    err[BIT_OV]  = ov_cond_i;
    err[BIT_UV]  = uv_cond_i;
    err[BIT_CLK] = clk_err;
    err[BIT_OC]  = s_next.lat[0];
    err[BIT_DC]  = s_next.lat[1];
    err[BIT_OT]  = s_next.lat[2];
    s_next.prev  = err;

    // fault pin and power stage
    s_next.fault_drv  = 1'b0;
    s_next.fault_oe_n = ~((|s_next.lat) | clk_err);
    s_next.pwr_en     = sd_n & ~(|s_next.lat) & ~clk_err
                      & ~ov_cond_i & ~uv_cond_i;

    // register writes
    if (we_i) begin
      case (addr_i)
        ADDR_CTRL: begin
          s_next.sd_bit = wdata_i[CTRL_SD_BIT];
        end
        ADDR_IRQ_STAT: begin
          s_next.irq_stat = s_reg.irq_stat & ~wdata_i[NUM_ERR-1:0];
        end
        ADDR_IRQ_MASK: begin
          s_next.irq_mask = wdata_i[NUM_ERR-1:0];
        end
        default: begin
          s_next.sd_bit = s_next.sd_bit;
        end
      endcase
    end
    s_next.irq_stat = s_next.irq_stat | (err & ~s_reg.prev);
    s_next.irq      = |(s_next.irq_stat & s_next.irq_mask);

    // register reads
    if (re_i) begin
      case (addr_i)
        ADDR_CTRL: begin
          s_next.rdata[CTRL_SD_BIT] = s_reg.sd_bit;
        end
        ADDR_ERR: begin
          s_next.rdata[NUM_ERR-1:0] = s_reg.prev;
          s_next.rdata[BIT_PIN]     = fault_out_n_i;
          s_next.rdata[BIT_REC]     = s_reg.timer != '0;
        end
        ADDR_IRQ_STAT: begin
          s_next.rdata[NUM_ERR-1:0] = s_reg.irq_stat;
        end
        ADDR_IRQ_MASK: begin
          s_next.rdata[NUM_ERR-1:0] = s_reg.irq_mask;
        end
        default: begin
          s_next.rdata = '0;
        end
      endcase
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg            <= '0;
      s_reg.sd_bit     <= CTRL_SD_RESET;
      s_reg.irq_mask   <= MASK_RESET;
      s_reg.fault_oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // outputs
  assign fault_out_n_o      = s_reg.fault_drv;
  assign fault_out_n_oe_n_o = s_reg.fault_oe_n;
  assign power_stage_en_o   = s_reg.pwr_en;
  assign rdata_o            = s_reg.rdata;
  assign irq_o              = s_reg.irq;

endmodule

`default_nettype wire

// >>> logic/amp_fault_pkg.sv
// constants, register map and timing for the amplifier fault manager
// assumes a 100 MHz core clock and a plain one-cycle register port
package amp_fault_pkg;

  // ==========================================================================
  // register port
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_ERR        = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h0C;

  // ==========================================================================
  // field positions and reset values
  localparam int          NUM_ERR         = 6;
  localparam int          NUM_CH          = 2;
  localparam int          BIT_OV          = 0;
  localparam int          BIT_UV          = 1;
  localparam int          BIT_CLK         = 2;
  localparam int          BIT_OC          = 3;
  localparam int          BIT_DC          = 4;
  localparam int          BIT_OT          = 5;
  localparam int          BIT_PIN         = 6;
  localparam int          BIT_REC         = 7;
  localparam int          CTRL_SD_BIT     = 0;
  localparam logic        CTRL_SD_RESET   = 1'b1;
  localparam logic [5:0]  MASK_RESET      = 6'h00;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned DC_DETECT_MS    = 420;
  localparam int unsigned DC_DETECT_CYC   = (CLK_HZ / 1000) * DC_DETECT_MS;
  localparam int unsigned RECOVERY_US     = 1000;
  localparam int unsigned RECOVERY_CYC    = (CLK_HZ / 1_000_000) * RECOVERY_US;
  localparam int          CNT_W           = 32;

  // duty measurement window for dc detection
  localparam int unsigned DUTY_WIN        = 256;
  localparam int unsigned DUTY_PCT        = 60;
  localparam int unsigned DUTY_THR        = (DUTY_WIN * DUTY_PCT) / 100;

endpackage

// >>> logic/dc_duty_monitor.sv
// per-channel differential duty monitor for dc detection
// assumes output pwm levels synchronous to core_clk_i
`timescale 1ns/100ps
`default_nettype none

module dc_duty_monitor
  import amp_fault_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = DC_DETECT_CYC
) (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic out_p_i,
  input  wire logic out_n_i,
  output logic      dc_err_o
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [7:0]       win_cnt;
    logic [8:0]       pos_cnt;
    logic [8:0]       neg_cnt;
    logic             pol;
    logic             pol_valid;
    logic [CNT_W-1:0] hold;
    logic             err;
  } mon_state_t;

  mon_state_t s_reg;
  mon_state_t s_next;

  // ==========================================================================
  // duty counting
  always_comb begin
    logic [8:0] pos_sum;
    logic [8:0] neg_sum;
    logic       hi_pos;
    logic       hi_neg;
    pos_sum = s_reg.pos_cnt + {8'h00, out_p_i & ~out_n_i};
    neg_sum = s_reg.neg_cnt + {8'h00, out_n_i & ~out_p_i};
    hi_pos  = pos_sum > 9'(DUTY_THR);
    hi_neg  = neg_sum > 9'(DUTY_THR);
    s_next  = s_reg;
    s_next.win_cnt = s_reg.win_cnt + 8'h01;
    s_next.pos_cnt = pos_sum;
    s_next.neg_cnt = neg_sum;
    if (s_reg.win_cnt == 8'(DUTY_WIN - 1)) begin
      s_next.pos_cnt = 9'h000;
      s_next.neg_cnt = 9'h000;
      if (hi_pos || hi_neg) begin
        s_next.pol       = hi_pos;
        s_next.pol_valid = 1'b1;
        if (s_reg.pol_valid && (s_reg.pol == hi_pos)) begin
          if (s_reg.hold <= CNT_W'(HOLD_CYCLES)) begin
            s_next.hold = s_reg.hold + CNT_W'(DUTY_WIN);
          end
        end else begin
          s_next.hold = CNT_W'(DUTY_WIN);
        end
      end else begin
        s_next.pol_valid = 1'b0;
        s_next.hold      = '0;
      end
    end
    s_next.err = s_next.hold > CNT_W'(HOLD_CYCLES);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dc_err_o = s_reg.err;

endmodule

`default_nettype wire

// >>> test/amp_fault_props.sv
// assertions on the fault manager ports
// assumes bind onto amp_fault_manager
`timescale 1ns/100ps
`default_nettype none

module amp_fault_props
  import amp_fault_pkg::*;
#(
  parameter int unsigned RECOVERY_CYCLES = RECOVERY_CYC
) (
  input wire logic              core_clk_i,
  input wire logic              rst_n_i,
  input wire logic              ov_cond_i,
  input wire logic              uv_cond_i,
  input wire logic              clk_ratio_bad_i,
  input wire logic              clk_rate_bad_i,
  input wire logic              clk_stopped_i,
  input wire logic              oc_cond_i,
  input wire logic              ot_cond_i,
  input wire logic              amp_shutdown_n_i,
  input wire logic              fault_out_n_o,
  input wire logic              fault_out_n_oe_n_o,
  input wire logic              power_stage_en_o,
  input wire logic              re_i,
  input wire logic [DATA_W-1:0] rdata_o
);
  // ====
  // helpers
  wire logic clk_any;
  assign clk_any = clk_ratio_bad_i | clk_rate_bad_i | clk_stopped_i;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ====
  // properties
  drive_zero_a: assert property (fault_out_n_o == 1'b0)
    else $error("fault drive value not zero");
  clk_err_fault_a: assert property (clk_any |=> !fault_out_n_oe_n_o)
    else $error("clock error did not pull fault");
  fault_release_a: assert property ($rose(fault_out_n_oe_n_o) |-> !$past(clk_any))
    else $error("fault released during clock error");
  latch_hold_a: assert property ($fell(fault_out_n_oe_n_o) && !$past(clk_any)
    |-> !fault_out_n_oe_n_o [*8]) else $error("latched fault released early");
  nonlatch_quiet_a: assert property ($rose(ov_cond_i | uv_cond_i) && fault_out_n_oe_n_o
    && !clk_any && !oc_cond_i && !ot_cond_i |=> fault_out_n_oe_n_o)
    else $error("supply error pulled fault");
  err_power_a: assert property (ov_cond_i || uv_cond_i || clk_any |=> !power_stage_en_o)
    else $error("power stage on during error");
  shutdown_power_a: assert property (!amp_shutdown_n_i |=> !power_stage_en_o)
    else $error("power stage on in shutdown");
  rdata_idle_a: assert property (!$past(re_i) |-> rdata_o == '0)
    else $error("read data outside read slot");
endmodule

bind amp_fault_manager amp_fault_props #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) props_i (
  .core_clk_i, .rst_n_i, .ov_cond_i, .uv_cond_i, .clk_ratio_bad_i, .clk_rate_bad_i,
  .clk_stopped_i, .oc_cond_i, .ot_cond_i, .amp_shutdown_n_i, .fault_out_n_o,
  .fault_out_n_oe_n_o, .power_stage_en_o, .re_i, .rdata_o);

`default_nettype wire

// >>> test/host_ctrl_model.sv
// host controller model on the fault and shutdown pins
// assumes a pulled-up fault wire resolved by the bench
`timescale 1ns/100ps
`default_nettype none

module host_ctrl_model (
  input  wire logic fault_wire_i,
  input  wire logic tie_i,
  input  wire logic sd_req_i,
  output logic      amp_shutdown_n_o
);
  // ====
  // shutdown source: own request or fault wire tied back
  assign amp_shutdown_n_o = tie_i ? fault_wire_i : sd_req_i;
endmodule

`default_nettype wire

// >>> test/tb_amp_fault_manager.sv
// self-checking bench for the amplifier fault manager
// assumes checker and host model compiled before it
`timescale 1ns/100ps
`default_nettype none

module tb_amp_fault_manager;
  import amp_fault_pkg::*;
  localparam int REC = 20;
  // ====
  // signals
  logic              core_clk_i, rst_n_i, ov, uv, oc, ot, hyst, sd_req, tie, we, re;
  logic [2:0]        clk_bad;
  logic [NUM_CH-1:0] out_p, out_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic              fault_o, oe_n, pwr, irq, sd_n;
  wire logic         fault_wire;
  int                fail_count, n_checks;

  assign fault_wire = oe_n ? 1'b1 : fault_o;
  amp_fault_manager #(.DC_CYCLES(1024), .RECOVERY_CYCLES(REC)) amp_fault_manager_i (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ov_cond_i(ov), .uv_cond_i(uv),
    .clk_ratio_bad_i(clk_bad[0]), .clk_rate_bad_i(clk_bad[1]), .clk_stopped_i(clk_bad[2]),
    .oc_cond_i(oc), .ot_cond_i(ot), .ot_below_hyst_i(hyst), .out_p_i(out_p), .out_n_i(out_n),
    .amp_shutdown_n_i(sd_n), .fault_out_n_i(fault_wire), .fault_out_n_o(fault_o),
    .fault_out_n_oe_n_o(oe_n), .power_stage_en_o(pwr), .addr_i(addr), .wdata_i(wdata),
    .we_i(we), .re_i(re), .rdata_o(rdata), .irq_o(irq));
  host_ctrl_model host_ctrl_model_i (.fault_wire_i(fault_wire), .tie_i(tie),
    .sd_req_i(sd_req), .amp_shutdown_n_o(sd_n));

  // ====
  // tasks
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    step(1);
    we <= 1'b0;
    step(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    addr <= a;
    re <= 1'b1;
    step(1);
    re <= 1'b0;
    step(1);
    chk(what, rdata, exp);
  endtask
  task automatic tog(input int n);
    sd_req <= 1'b0;
    step(n);
    sd_req <= 1'b1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ====
  // clock and watchdog
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    step(20000);
    fail_count++;
    tally_and_finish();
  end

  // ====
  // tests
  initial begin
    {rst_n_i, ov, uv, oc, ot, we, re, tie} = '0;
    {clk_bad, out_p, out_n, addr, wdata} = '0;
    {hyst, sd_req} = 2'b11;
    {fail_count, n_checks} = '0;
    step(5);
    rst_n_i <= 1'b1;
    step(2);
    chk("power", 32'(pwr), 1);
    rd(ADDR_CTRL, 1, "ctrl");
    rd(ADDR_IRQ_MASK, 0, "mask");
    rd(ADDR_ERR, 32'h40, "err");
    $display("done reset");
    for (int i = 0; i < 2; i++) begin
      {uv, ov} <= 2'b01 << i;
      step(3);
      chk("supply oe", 32'(oe_n), 1);
      chk("supply power", 32'(pwr), 0);
      rd(ADDR_ERR, 32'h40 | (1 << i), "supply err");
      {uv, ov} <= 2'b00;
      step(3);
      chk("supply back", 32'(pwr), 1);
    end
    for (int k = 0; k < 3; k++) begin
      clk_bad <= 3'b001 << k;
      step(3);
      chk("clk oe", 32'(oe_n), 0);
      rd(ADDR_ERR, 32'h04, "clk err");
      clk_bad <= 3'b000;
      step(2);
      chk("clk free", 32'(oe_n), 1);
    end
    rd(ADDR_IRQ_STAT, 32'h07, "stat");
    chk("irq masked", 32'(irq), 0);
    wr(ADDR_IRQ_STAT, 32'h07);
    rd(ADDR_IRQ_STAT, 0, "stat clr");
    $display("done nonlatching");
    wr(ADDR_IRQ_MASK, 32'h08);
    oc <= 1'b1;
    step(1);
    oc <= 1'b0;
    step(2);
    chk("oc oe", 32'(oe_n), 0);
    rd(ADDR_ERR, 32'h88, "oc err");
    chk("irq", 32'(irq), 1);
    tog(3);
    step(8);
    chk("oc held", 32'(oe_n), 0);
    step(REC);
    chk("oc done", 32'(oe_n), 1);
    wr(ADDR_IRQ_STAT, 32'h08);
    step(1);
    chk("irq clr", 32'(irq), 0);
    oc <= 1'b1;
    step(3);
    tog(REC + 5);
    step(3);
    chk("relatch", 32'(oe_n), 0);
    oc <= 1'b0;
    tog(3);
    step(REC + 5);
    chk("relatch clr", 32'(oe_n), 1);
    $display("done overcurrent");
    hyst <= 1'b0;
    ot <= 1'b1;
    step(1);
    ot <= 1'b0;
    wr(ADDR_CTRL, 0);
    wr(ADDR_CTRL, 1);
    step(REC + 5);
    chk("ot held", 32'(oe_n), 0);
    hyst <= 1'b1;
    step(3);
    chk("ot clr", 32'(oe_n), 1);
    tie <= 1'b1;
    oc <= 1'b1;
    step(1);
    oc <= 1'b0;
    step(4);
    chk("tie sd", 32'(sd_n), 0);
    step(REC + 5);
    chk("tie oe", 32'(oe_n), 1);
    tie <= 1'b0;
    $display("done overtemp and tie");
    out_p <= 2'b01;
    step(512);
    chk("dc early", 32'(oe_n), 1);
    step(1200);
    chk("dc oe", 32'(oe_n), 0);
    rd(ADDR_ERR, 32'h10, "dc err");
    out_p <= 2'b00;
    tog(600);
    step(5);
    chk("dc clr", 32'(oe_n), 1);
    out_n <= 2'b10;
    step(1800);
    chk("dc neg", 32'(oe_n), 0);
    out_n <= 2'b00;
    tog(600);
    step(5);
    chk("dc neg clr", 32'(oe_n), 1);
    $display("done dc");
    tally_and_finish();
  end
endmodule

`default_nettype wire
